// file: src/aab_alu.sv
// accumulator alu with bit operations, skip control and axi4-lite registers
// Overview of operation
// RULE_01 - add immediate: acc plus 8-bit literal into acc, update C, half carry, Z.
// RULE_02 - add register: acc plus addressed register, update C, half carry, Z.
// RULE_03 - register ops: destination bit 0 writes acc, 1 writes register.
// RULE_04 - and immediate: acc AND literal into acc, only Z changes.
// RULE_05 - and register: acc AND register to selected destination, only Z changes.
// RULE_06 - clear bit: one selected register bit forced low, flags untouched.
// RULE_07 - set bit: one selected register bit forced high, flags untouched.
// RULE_08 - skip if low: bit zero discards next instruction as a nop.
// RULE_09 - skip if high: bit one discards next instruction, flags untouched.
// RULE_10 - a true test costs a second cycle executed as a nop.
// RULE_11 - port register operands come from pin levels, not output latches.
// RULE_12 - Z on zero result, C out of bit 7, half carry out of bit 3.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "aab_params.svh"
module aab_alu
  import aab_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // instruction issue
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [13:0] instr_word,
  // data register file
  output logic       [6:0] reg_raddr,
  input  wire logic  [7:0] reg_rdata,
  output logic             reg_we,
  output logic       [6:0] reg_waddr,
  output logic       [7:0] reg_wdata,
  // port pins
  input  wire logic  [7:0] pin_level,
  // core state
  output logic       [7:0] acc_value,
  output logic             flag_c,
  output logic             half_carry_flag,
  output logic             flag_z,
  output logic             nop_cycle,
  // axi4-lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic  [7:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic  [3:0] wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic       [1:0] bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic  [7:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic       [1:0] rresp
);

  localparam aab_regs_t RST_VAL = '{state: st_exec, ctrl: `AAB_RST_CTRL, acc: `AAB_RST_ACC,
                                   port_addr: `AAB_RST_PORT, default: '0};

  // ==========================================================
  // reset release
  logic      rst_s1_q;
  logic      rst_s2_q;
  aab_regs_t st_q;
  aab_regs_t st_d;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // decode and operands
  logic       instr_take;
  logic       add_immediate_to_acc;
  logic       add_acc_to_register;
  logic       and_immediate_with_acc;
  logic       and_acc_with_register;
  logic       clear_single_bit;
  logic       set_single_bit;
  logic       skip_if_bit_low;
  logic       skip_if_bit_high;
  logic       to_reg;
  logic [2:0] bit_idx;
  logic [7:0] bit_mask;
  logic [7:0] literal;
  logic       port_hit;
  logic [7:0] opnd;
  logic [7:0] add_b;
  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [7:0] and_r;
  logic       skip_hit;
  logic       sw_apply;
  logic       acc_sw_wr;

  assign instr_ready            = st_q.ctrl[`AAB_CTRL_EN_BIT];
  assign instr_take             = instr_valid && instr_ready;
  assign add_immediate_to_acc   = instr_word[13:9] == `AAB_OP_ADD_IMM_TO_ACC;
  assign add_acc_to_register    = instr_word[13:8] == `AAB_OP_ADD_ACC_TO_REG;
  assign and_immediate_with_acc = instr_word[13:8] == `AAB_OP_AND_IMM_WITH_ACC;
  assign and_acc_with_register  = instr_word[13:8] == `AAB_OP_AND_ACC_WITH_REG;
  assign clear_single_bit       = instr_word[13:10] == `AAB_OP_CLEAR_BIT;
  assign set_single_bit         = instr_word[13:10] == `AAB_OP_SET_BIT;
  assign skip_if_bit_low        = instr_word[13:10] == `AAB_OP_SKIP_LOW;
  assign skip_if_bit_high       = instr_word[13:10] == `AAB_OP_SKIP_HIGH;
  assign to_reg                 = instr_word[`AAB_F_DEST];
  assign bit_idx                = instr_word[`AAB_F_BIT_HI:`AAB_F_BIT_LO];
  assign bit_mask               = 8'h01 << bit_idx;
  assign literal                = instr_word[7:0];
  assign reg_raddr              = instr_word[6:0];

  // forwarding covers the write still in flight to the register file
  assign port_hit = st_q.ctrl[`AAB_CTRL_PORT_BIT] && (reg_raddr == st_q.port_addr);
  always_comb begin
    if (port_hit) begin
      opnd = st_q.pin_val; // RULE_11
    end else if (st_q.wr_en && st_q.wr_addr == reg_raddr) begin
      opnd = st_q.wr_data;
    end else begin
      opnd = reg_rdata;
    end
  end

  assign add_b    = add_immediate_to_acc ? literal : opnd;
  assign sum9     = {1'b0, st_q.acc} + {1'b0, add_b};
  assign sum_lo   = {1'b0, st_q.acc[3:0]} + {1'b0, add_b[3:0]};
  assign and_r    = st_q.acc & (and_immediate_with_acc ? literal : opnd);
  assign skip_hit = (skip_if_bit_low && !opnd[bit_idx]) || (skip_if_bit_high && opnd[bit_idx]);
  assign sw_apply = st_q.aw_got && st_q.w_got;
  assign acc_sw_wr = sw_apply && st_q.w_strb[0] && ({st_q.aw_addr[7:2], 2'b00} == `AAB_OFF_ACC);

  // ==========================================================
  // next state
  always_comb begin
    st_d        = st_q;
    st_d.pin_s1 = pin_level;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;
    if (st_q.pin_s2 == st_q.pin_s3) begin
      st_d.pin_val = st_q.pin_s3;
    end
    st_d.wr_en = 1'b0;
    case (st_q.state)
      st_flush: begin
        // the instruction that arrives now is dropped
        if (instr_take) begin
          st_d.state = st_exec; // RULE_10
        end
      end
      st_exec: begin
        if (instr_take) begin
          st_d.count = st_q.count + 16'h0001;
          if (add_immediate_to_acc || add_acc_to_register) begin
            st_d.flag_c          = sum9[8]; // RULE_12
            st_d.half_carry_flag = sum_lo[4]; // RULE_12
            st_d.flag_z          = sum9[7:0] == 8'h00; // RULE_12
            if (add_acc_to_register && to_reg) begin
              st_d.wr_en   = 1'b1; // RULE_03
              st_d.wr_addr = reg_raddr;
              st_d.wr_data = sum9[7:0]; // RULE_02
            end else begin
              st_d.acc = sum9[7:0]; // RULE_01 RULE_02
            end
          end
          if (and_immediate_with_acc || and_acc_with_register) begin
            st_d.flag_z = and_r == 8'h00; // RULE_04 RULE_05
            if (and_acc_with_register && to_reg) begin
              st_d.wr_en   = 1'b1; // RULE_03
              st_d.wr_addr = reg_raddr;
              st_d.wr_data = and_r; // RULE_05
            end else begin
              st_d.acc = and_r; // RULE_04 RULE_05
            end
          end
          if (clear_single_bit || set_single_bit) begin
            st_d.wr_en   = 1'b1;
            st_d.wr_addr = reg_raddr;
            st_d.wr_data = set_single_bit ? (opnd | bit_mask) : (opnd & ~bit_mask); // RULE_06 RULE_07
          end
          if (skip_hit) begin
            st_d.state = st_flush; // RULE_08 RULE_09 RULE_10
          end
        end
      end
      default: begin
        st_d.state = st_exec;
      end
    endcase

    // bus write last, so software wins a same-cycle clash on acc
    if (awvalid && awready) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (sw_apply) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = `AAB_RESP_OK;
      case ({st_q.aw_addr[7:2], 2'b00})
        `AAB_OFF_CTRL: begin
          if (st_q.w_strb[0]) begin
            st_d.ctrl = st_q.w_data[1:0];
          end
        end
        `AAB_OFF_ACC: begin
          if (st_q.w_strb[0]) begin
            st_d.acc = st_q.w_data[7:0];
          end
        end
        `AAB_OFF_PORT: begin
          if (st_q.w_strb[0]) begin
            st_d.port_addr = st_q.w_data[6:0];
          end
        end
        `AAB_OFF_STATUS, `AAB_OFF_COUNT: begin
          st_d.bresp = `AAB_RESP_OK;
        end
        default: begin
          st_d.bresp = `AAB_RESP_ERR;
        end
      endcase
    end

    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `AAB_RESP_OK;
      st_d.rdata  = 32'h0000_0000;
      case ({araddr[7:2], 2'b00})
        `AAB_OFF_CTRL:   st_d.rdata[1:0] = st_q.ctrl;
        `AAB_OFF_ACC:    st_d.rdata[7:0] = st_q.acc;
        `AAB_OFF_STATUS: begin
          st_d.rdata[`AAB_ST_C_BIT]          = st_q.flag_c;
          st_d.rdata[`AAB_ST_HALF_CARRY_BIT] = st_q.half_carry_flag;
          st_d.rdata[`AAB_ST_Z_BIT]          = st_q.flag_z;
        end
        `AAB_OFF_PORT:   st_d.rdata[6:0]  = st_q.port_addr;
        `AAB_OFF_COUNT:  st_d.rdata[15:0] = st_q.count;
        default:         st_d.rresp = `AAB_RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      st_q <= RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign awready         = !st_q.aw_got && !st_q.bvalid;
  assign wready          = !st_q.w_got && !st_q.bvalid;
  assign arready         = !st_q.rvalid;
  assign bvalid          = st_q.bvalid;
  assign bresp           = st_q.bresp;
  assign rvalid          = st_q.rvalid;
  assign rdata           = st_q.rdata;
  assign rresp           = st_q.rresp;
  assign reg_we          = st_q.wr_en;
  assign reg_waddr       = st_q.wr_addr;
  assign reg_wdata       = st_q.wr_data;
  assign acc_value       = st_q.acc;
  assign flag_c          = st_q.flag_c;
  assign half_carry_flag = st_q.half_carry_flag;
  assign flag_z          = st_q.flag_z;
  assign nop_cycle       = st_q.state == st_flush;

  // ==========================================================
  // checks
  logic       exec_take;
  logic [2:0] flags_w;
  assign exec_take = instr_take && !nop_cycle;
  assign flags_w   = {st_q.flag_c, st_q.half_carry_flag, st_q.flag_z};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_s2_q);

  sequence skip_taken_s;
    exec_take && skip_hit;
  endsequence
  sequence flush_done_s;
    nop_cycle && instr_take;
  endsequence

  add_imm_a: assert property (exec_take && add_immediate_to_acc && !acc_sw_wr |=> // RULE_01
    acc_value == 8'($past(st_q.acc) + $past(literal))) else $error("add immediate result wrong");
  add_reg_a: assert property (exec_take && add_acc_to_register && !to_reg && !acc_sw_wr |=> // RULE_02
    acc_value == 8'($past(st_q.acc) + $past(opnd)) && !reg_we) else $error("add register result wrong");
  dest_reg_a: assert property (exec_take && (add_acc_to_register || and_acc_with_register) && to_reg // RULE_03
    && !acc_sw_wr |=> reg_we && reg_waddr == $past(reg_raddr) && $stable(acc_value))
    else $error("destination select wrong");
  and_imm_a: assert property (exec_take && and_immediate_with_acc && !acc_sw_wr |=> // RULE_04
    acc_value == ($past(st_q.acc) & $past(literal)) && $stable(flag_c) && $stable(half_carry_flag))
    else $error("and immediate wrong");
  and_reg_a: assert property (exec_take && and_acc_with_register && !to_reg && !acc_sw_wr |=> // RULE_05
    acc_value == ($past(st_q.acc) & $past(opnd)) && flag_z == (acc_value == 8'h00) && $stable(flag_c))
    else $error("and register wrong");
  bit_clear_a: assert property (exec_take && clear_single_bit |=> reg_we && $stable(flags_w) // RULE_06
    && reg_wdata == ($past(opnd) & ~$past(bit_mask))) else $error("bit clear wrong");
  bit_set_a: assert property (exec_take && set_single_bit |=> reg_we && $stable(flags_w) // RULE_07
    && reg_wdata == ($past(opnd) | $past(bit_mask))) else $error("bit set wrong");
  skip_low_a: assert property (exec_take && skip_if_bit_low |=> // RULE_08
    nop_cycle == !$past(opnd[bit_idx])) else $error("skip if low wrong");
  skip_high_a: assert property (exec_take && skip_if_bit_high |=> // RULE_09
    nop_cycle == $past(opnd[bit_idx]) && $stable(flags_w)) else $error("skip if high wrong");
  nop_slot_a: assert property (skip_taken_s ##1 flush_done_s |=> !nop_cycle && !reg_we // RULE_10
    && $stable(st_q.count) && $stable(flags_w)) else $error("skipped slot not a nop");
  port_src_a: assert property (exec_take && port_hit && set_single_bit |=> // RULE_11
    reg_wdata == ($past(st_q.pin_val) | $past(bit_mask))) else $error("port operand not from pins");
  add_flags_a: assert property (exec_take && (add_immediate_to_acc || add_acc_to_register) |=> // RULE_12
    flag_c == $past(sum9[8]) && half_carry_flag == $past(sum_lo[4]) && flag_z == ($past(sum9) == 9'h100
    || $past(sum9) == 9'h000)) else $error("add flags wrong");

endmodule : aab_alu
`default_nettype wire

// file: src/aab_params.svh
// offsets, field positions, opcodes and reset values of the accumulator alu
`ifndef AAB_PARAMS_SVH
`define AAB_PARAMS_SVH
`define AAB_OFF_CTRL 8'h00
`define AAB_OFF_ACC 8'h04
`define AAB_OFF_STATUS 8'h08
`define AAB_OFF_PORT 8'h0c
`define AAB_OFF_COUNT 8'h10
`define AAB_CTRL_EN_BIT 0
`define AAB_CTRL_PORT_BIT 1
`define AAB_ST_C_BIT 0
`define AAB_ST_HALF_CARRY_BIT 1
`define AAB_ST_Z_BIT 2
`define AAB_RST_CTRL 2'h3
`define AAB_RST_ACC 8'h00
`define AAB_RST_PORT 7'h00
`define AAB_RESP_OK 2'h0
`define AAB_RESP_ERR 2'h2
`define AAB_F_DEST 7
`define AAB_F_BIT_HI 9
`define AAB_F_BIT_LO 7
`define AAB_OP_ADD_ACC_TO_REG 6'h07
`define AAB_OP_AND_ACC_WITH_REG 6'h05
`define AAB_OP_AND_IMM_WITH_ACC 6'h39
`define AAB_OP_ADD_IMM_TO_ACC 5'h1f
`define AAB_OP_CLEAR_BIT 4'h4
`define AAB_OP_SET_BIT 4'h5
`define AAB_OP_SKIP_LOW 4'h6
`define AAB_OP_SKIP_HIGH 4'h7
`endif

// file: src/aab_pkg.sv
// types of the accumulator alu
`default_nettype none
package aab_pkg;
  typedef enum logic [1:0] {
    st_exec  = 2'b01,
    st_flush = 2'b10
  } aab_state_t;

  typedef struct packed {
    aab_state_t  state;
    logic [1:0]  ctrl;
    logic [7:0]  acc;
    logic        flag_c;
    logic        half_carry_flag;
    logic        flag_z;
    logic [6:0]  port_addr;
    logic [15:0] count;
    logic        wr_en;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic [7:0]  pin_s3;
    logic [7:0]  pin_val;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } aab_regs_t;
endpackage : aab_pkg
`default_nettype wire

// file: src/unused_placeholder_none.sv
// no content beyond this comment: intentionally empty unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: sim/tb_accumulator_alu_bit_ops.sv
// self-checking bench of the accumulator alu with bit operations
`timescale 1ns/100ps
`default_nettype none
`include "aab_params.svh"
module tb_accumulator_alu_bit_ops;
  logic        clock, rst_n, instr_valid, instr_ready, reg_we, flag_c, half_carry_flag, flag_z, nop_cycle;
  logic [13:0] instr_word;
  logic [6:0]  reg_raddr, reg_waddr, e_wa, port_a;
  logic [7:0]  reg_rdata, reg_wdata, pin_level, acc_value, e_acc, e_wd, awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic [7:0]  mem [128];
  logic [7:0]  mmem [128];
  logic        e_c, e_dc, e_z, e_nop, e_we, skip_p, port_en, chk_on;
  logic [15:0] cnt;
  int          num_errors, total_checks;

  aab_alu aab_alu_inst (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_word(instr_word), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .reg_we(reg_we),
    .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .pin_level(pin_level), .acc_value(acc_value),
    .flag_c(flag_c), .half_carry_flag(half_carry_flag), .flag_z(flag_z), .nop_cycle(nop_cycle),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // ==========================================================
  // register file stand-in
  assign reg_rdata = mem[reg_raddr];
  always @(posedge clock) if (reg_we) mem[reg_waddr] <= reg_wdata;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // checking
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask : close_out

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      total_checks++;
      if (seen !== exp) begin
        num_errors++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask : chk

  task timeout(input string nm);
    begin
      num_errors++;
      $display("mismatch %s expected answer seen none", nm);
      close_out();
    end
  endtask : timeout

  // settled core state compared every cycle against the model while chk_on is set
  always @(negedge clock) begin
    if (chk_on) begin
      chk("acc", 32'(acc_value), 32'(e_acc));
      chk("carry", 32'(flag_c), 32'(e_c));
      chk("half_carry", 32'(half_carry_flag), 32'(e_dc));
      chk("zero", 32'(flag_z), 32'(e_z));
      chk("nop", 32'(nop_cycle), 32'(e_nop));
      chk("reg_we", 32'(reg_we), 32'(e_we));
      if (e_we) begin
        chk("waddr", 32'(reg_waddr), 32'(e_wa));
        chk("wdata", 32'(reg_wdata), 32'(e_wd));
      end
    end
  end

  // ==========================================================
  // instruction driver and reference model
  task automatic issue(input int kd, input logic [6:0] f, input logic [2:0] b, input logic d, input logic [7:0] k);
    logic [8:0]  s;
    logic [7:0]  op, x, r;
    logic [13:0] w;
    begin
      case (kd)
        0: w = {`AAB_OP_ADD_IMM_TO_ACC, 1'b0, k};
        1: w = {`AAB_OP_ADD_ACC_TO_REG, d, f};
        2: w = {`AAB_OP_AND_IMM_WITH_ACC, k};
        3: w = {`AAB_OP_AND_ACC_WITH_REG, d, f};
        4: w = {`AAB_OP_CLEAR_BIT, b, f};
        5: w = {`AAB_OP_SET_BIT, b, f};
        6: w = {`AAB_OP_SKIP_LOW, b, f};
        7: w = {`AAB_OP_SKIP_HIGH, b, f};
        // code outside the decoded subset: taken and counted, no effect
        default: w = {6'h00, d, f};
      endcase
      instr_valid <= 1'b1;
      instr_word  <= w;
      @(posedge clock);
      e_we = 1'b0;
      r = 8'h00;
      op = (port_en && f == port_a) ? pin_level : mmem[f];
      x = (kd == 0 || kd == 2) ? k : op;
      if (skip_p) skip_p = 1'b0;
      else begin
        cnt++;
        if (kd < 2) begin
          s = {1'b0, e_acc} + {1'b0, x};
          e_dc = ({1'b0, e_acc[3:0]} + {1'b0, x[3:0]}) > 5'h0f;
          e_c = s[8];
          r = s[7:0];
        end else if (kd < 4) r = e_acc & x;
        else if (kd == 4) r = op & ~(8'h01 << b);
        else if (kd == 5) r = op | (8'h01 << b);
        else if (kd < 8) skip_p = (op[b] == (kd == 7));
        if (kd < 4) e_z = (r == 8'h00);
        if (kd == 0 || kd == 2 || (kd < 4 && !d)) e_acc = r;
        else if (kd < 6) begin
          e_we = 1'b1;
          e_wa = f;
          e_wd = r;
          mmem[f] = r;
        end
      end
      e_nop = skip_p;
    end
  endtask : issue

  task idle(input int n);
    begin
      instr_valid <= 1'b0;
      repeat (n) begin
        @(posedge clock);
        e_we = 1'b0;
      end
    end
  endtask : idle

  // port address drawn often so pin-sourced operands get exercised
  task automatic rnd(input int n);
    logic [6:0] f;
    begin
      repeat (n) begin
        f = ($urandom % 4 == 0) ? port_a : 7'($urandom);
        issue(int'($urandom % 9), f, 3'($urandom), 1'($urandom), 8'($urandom));
        if ($urandom % 8 == 0) idle(1);
        // new pin level needs four quiet edges to pass the filter
        if ($urandom % 16 == 0) begin
          pin_level <= 8'($urandom);
          idle(4);
        end
      end
      idle(1);
    end
  endtask : rnd

  // ==========================================================
  // axi4-lite master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic ad, wd;
    begin
      chk_on = 1'b0;
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      bready  <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      n = 0;
      while (n < 50) begin
        @(posedge clock);
        n++;
        if (bvalid) begin
          chk("bresp", 32'(bresp), 32'(er));
          bready <= 1'b0;
          n = 99;
        end else begin
          if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
          end
          if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
          end
        end
      end
      if (n == 50) timeout("bvalid");
      @(posedge clock);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ad;
    begin
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      ad = 1'b0;
      n = 0;
      while (n < 50) begin
        @(posedge clock);
        n++;
        if (rvalid) begin
          d = rdata;
          r = rresp;
          rready <= 1'b0;
          n = 99;
        end else if (!ad && arready) begin
          ad = 1'b1;
          arvalid <= 1'b0;
        end
      end
      if (n == 50) timeout("rvalid");
      @(posedge clock);
    end
  endtask : axi_rd

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(901));
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    pin_level = 8'($urandom);
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    {num_errors, total_checks} = {32'd0, 32'd0};
    {chk_on, e_c, e_dc, e_z, e_nop, e_we, skip_p} = 7'h00;
    e_acc = 8'h00;
    cnt = 16'h0000;
    port_en = 1'b1;
    port_a = 7'h00;
    foreach (mem[i]) begin
      mem[i] = 8'($urandom);
      mmem[i] = mem[i];
    end
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk_on = 1'b1;
    chk("ready", 32'(instr_ready), 32'h1);
    axi_rd(`AAB_OFF_CTRL, rd, rr);
    chk("ctrl", rd, 32'(`AAB_RST_CTRL));
    axi_rd(`AAB_OFF_PORT, rd, rr);
    chk("port", rd, 32'(`AAB_RST_PORT));
    $display("test reset done");
    // carry out of bit 3 and bit 7 at their exact boundaries
    issue(0, 7'h00, 3'h0, 1'b0, 8'h0f);
    issue(0, 7'h00, 3'h0, 1'b0, 8'h01);
    issue(0, 7'h00, 3'h0, 1'b0, 8'hf0);
    issue(2, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(8, 7'h05, 3'h0, 1'b1, 8'h00);
    idle(1);
    $display("test arithmetic corners done");
    // back-to-back skips with the dropped slot trying to change state
    issue(4, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(6, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(0, 7'h00, 3'h0, 1'b0, 8'h01);
    issue(7, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(5, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(7, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(5, 7'h10, 3'h0, 1'b0, 8'h00);
    issue(6, 7'h10, 3'h3, 1'b0, 8'h00);
    idle(1);
    $display("test skip corners done");
    rnd(500);
    $display("test random mix done");
    axi_wr(`AAB_OFF_ACC, 32'h5a, `AAB_RESP_OK);
    e_acc = 8'h5a;
    axi_wr(`AAB_OFF_STATUS, 32'h7, `AAB_RESP_OK);
    chk_on = 1'b1;
    axi_rd(`AAB_OFF_STATUS, rd, rr);
    chk("status", rd, {29'h0, e_z, e_dc, e_c});
    axi_rd(`AAB_OFF_COUNT, rd, rr);
    chk("count", rd, 32'(cnt));
    axi_rd(8'h20, rd, rr);
    chk("rresp", 32'(rr), 32'(`AAB_RESP_ERR));
    axi_wr(8'h24, 32'h1, `AAB_RESP_ERR);
    axi_wr(`AAB_OFF_PORT, 32'h11, `AAB_RESP_OK);
    port_a = 7'h11;
    chk_on = 1'b1;
    rnd(150);
    axi_wr(`AAB_OFF_CTRL, 32'h1, `AAB_RESP_OK);
    port_en = 1'b0;
    chk_on = 1'b1;
    rnd(150);
    axi_wr(`AAB_OFF_CTRL, 32'h0, `AAB_RESP_OK);
    chk_on = 1'b1;
    chk("ready", 32'(instr_ready), 32'h0);
    instr_valid <= 1'b1;
    instr_word <= {`AAB_OP_ADD_IMM_TO_ACC, 9'h001};
    repeat (4) @(posedge clock);
    idle(1);
    axi_wr(`AAB_OFF_CTRL, 32'h3, `AAB_RESP_OK);
    port_en = 1'b1;
    chk_on = 1'b1;
    rnd(100);
    $display("test register bus done");
    close_out();
  end
endmodule : tb_accumulator_alu_bit_ops
`default_nettype wire
